// File: rtc_i2c_pkg.sv
// shared constants for the rtc two-wire slave and its bus master
package rtc_i2c_pkg;
	// ****************************************
	// link framing
	// ****************************************
	localparam int         BYTE_BITS  = 8;      // data bits per byte
	localparam logic [3:0] ACK_SLOT   = 4'h8;   // bit count of ninth pulse
	localparam int         IDX_W      = 4;      // word address width used
	localparam logic       RW_READ    = 1'b1;   // eighth address bit, read
	localparam logic [6:0] SLAVE_ADDR = 7'h2a;  // arbitrary value
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 4;           // mclk period
	localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
	localparam int TICK_PERIOD_S = 1;           // internal time base
	localparam int TICK_CYCLES   = CLK_HZ * TICK_PERIOD_S;
	localparam logic [1:0] WDOG_FIRE = 2'h1;    // ticks seen before expiry
	localparam int SCL_PERIOD_NS = 48;          // generated link clock
	localparam int SCL_STEPS     = 3;           // low, high, high-sample
	localparam int STEP_CYCLES   =
		SCL_PERIOD_NS / (CLK_PERIOD_NS * SCL_STEPS);
endpackage

// File: i2c_link_if.sv
// two-wire link between the rtc slave and its bus master
`timescale 1ns/1ns
interface i2c_link_if;
	logic host_scl_o;    // master clock level when driving
	logic host_scl_oe_n; // master pulls clock, active low
	logic host_sda_o;    // master data level when driving
	logic host_sda_oe_n; // master pulls data, active low
	logic dev_sda_o;     // slave data level when driving
	logic dev_sda_oe_n;  // slave pulls data, active low
	logic scl;           // resolved clock wire
	logic sda;           // resolved data wire

	// pull-ups: a released line reads high, any driver pulling low wins
	assign scl = host_scl_oe_n | host_scl_o;
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

	modport device (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe_n
	);
	modport host (
		input  scl,
		input  sda,
		output host_scl_o,
		output host_scl_oe_n,
		output host_sda_o,
		output host_sda_oe_n
	);
endinterface

// File: rtc_sync_fifo.sv
// small synchronous fifo with a registered head word
`timescale 1ns/1ns
module rtc_sync_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];  // storage array
	logic [AW-1:0]    wr_ptr_q;       // next write slot
	logic [AW-1:0]    rd_ptr_q;       // next read slot
	logic [AW:0]      count_q;        // words held in the array
	logic             head_q;         // head register holds a word
	logic [WIDTH-1:0] head_data_q;    // head register contents

	// head refills, if the array holds a word, whenever it is empty or being drained
	wire push   = in_valid & in_ready;
	wire refill = (count_q != '0) & (~head_q | out_ready);

	assign in_ready  = count_q != (AW+1)'(DEPTH);
	assign out_valid = head_q;
	assign out_data  = head_data_q;

	// array write side
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// pointers, fill count and head register
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wr_ptr_q    <= '0;
			rd_ptr_q    <= '0;
			count_q     <= '0;
			head_q      <= 1'b0;
			head_data_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (refill) begin
				rd_ptr_q    <= rd_ptr_q + 1'b1;
				head_data_q <= mem_q[rd_ptr_q];
				head_q      <= 1'b1;
			end else if (out_ready) begin
				head_q <= 1'b0;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(refill);
		end
	end
endmodule

// File: rtc_i2c_slave.sv
// rtc two-wire slave: framing, addressing, word index and watchdog
// Summary of operation
// - one bit per clock pulse, steady high
// - both lines high means idle bus
// - data falling while clock high is start
// - data rising while clock high is stop
// - master starts only on an idle bus
// - no limit on bytes per transaction
// - ninth clock pulse is the acknowledge slot
// - slave acknowledges received bytes, except when not addressed or fifo full
// - master acknowledges read bytes except last
// - acknowledger holds data low through pulse
// - read ends on no-ack; slave releases data
// - first byte after start selects the slave
// - slave never drives clock; data open-drain
// - low four index bits select register
// - timekeeping frozen while access in progress
// - stuck access aborted, timekeeping resumes
// - start or stop halts the watchdog
// - each expiry loses exactly one second
// - expiry between one and two seconds
`timescale 1ns/1ns
module rtc_i2c_slave #(
	parameter int TICK_CYCLES = rtc_i2c_pkg::TICK_CYCLES,
	parameter int FIFO_DEPTH  = 8
) (
	input  wire logic       mclk,
	input  wire logic       reset,
	i2c_link_if.device      link,
	output logic            wr_valid,
	input  wire logic       wr_ready,
	output logic [7:0]      wr_data,
	output logic [3:0]      wr_idx,
	output logic [3:0]      rd_idx,
	input  wire logic [7:0] rd_data,
	output logic            rd_take,
	output logic            freeze,
	output logic            sec_tick,
	output logic            wdog_expire,
	output logic            busy
);
	localparam int TW = $clog2(TICK_CYCLES);
	localparam int FW = rtc_i2c_pkg::IDX_W + rtc_i2c_pkg::BYTE_BITS;
	typedef enum logic [2:0] {
		S_IDLE,    // bus idle or between transactions
		S_ADDR,    // taking the address byte
		S_WIDX,    // taking the word index byte
		S_WDATA,   // taking write data bytes
		S_RDATA,   // shifting read data out
		S_IGNORE   // not addressed, wait for start or stop
	} dev_state_e;
	// ****************************************
	// link synchronisers and condition detect
	// ****************************************
	logic [1:0] scl_sync_q;  // clock pin, two-stage synchroniser
	logic [1:0] sda_sync_q;  // data pin, two-stage synchroniser
	logic       scl_prev_q;  // synchronised clock one cycle late
	logic       sda_prev_q;  // synchronised data one cycle late
	// only the second stage feeds the edge logic
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], link.scl};
			sda_sync_q <= {sda_sync_q[0], link.sda};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end
	wire scl_s    = scl_sync_q[1];
	wire sda_s    = sda_sync_q[1];
	wire scl_high = scl_s & scl_prev_q;
	wire scl_rise = scl_s & ~scl_prev_q;  // data sampled here
	wire scl_fall = ~scl_s & scl_prev_q;
	// data moving while clock high is a control, never data
	wire start_det = scl_high & sda_prev_q & ~sda_s;
	wire stop_det  = scl_high & ~sda_prev_q & sda_s;
	// ****************************************
	// one second time base and watchdog
	// ****************************************
	logic [TW-1:0] pre_q;     // prescaler toward the 1 Hz tick
	logic [1:0]    wd_cnt_q;  // ticks seen since address match
	logic          freeze_q;  // access in progress, watchdog armed
	wire tick_w   = pre_q == TW'(TICK_CYCLES - 1);
	// the first tick after a match is never enough, the second always
	// fires, so expiry lands between one and two seconds
	wire expire_w = freeze_q & tick_w &
		(wd_cnt_q == rtc_i2c_pkg::WDOG_FIRE);
	// ****************************************
	// byte engine
	// ****************************************
	dev_state_e state_q;     // transaction state
	logic [3:0] cnt_q;       // bits moved in this byte
	logic       ack_q;       // inside the ninth pulse
	logic [7:0] shift_q;     // receive or transmit shifter
	logic       sda_oe_n_q;  // data pull-down, active low
	logic [3:0] idx_q;       // register index, wraps freely
	logic       mack_q;      // master acknowledged last read byte
	logic       push_rdy;    // fifo can take a write byte
	wire byte_done = ~ack_q & scl_fall & (cnt_q == rtc_i2c_pkg::ACK_SLOT);
	wire addr_hit  = shift_q[7:1] == rtc_i2c_pkg::SLAVE_ADDR;
	wire is_read   = shift_q[0] == rtc_i2c_pkg::RW_READ;
	// only the byte right after start can claim the bus
	wire claim_w   = byte_done & (state_q == S_ADDR) & addr_hit;
	wire push_w    = byte_done & (state_q == S_WDATA) & push_rdy;
	// a full fifo answers with no-ack instead of losing the byte
	wire ack_give  = claim_w | push_w |
		(byte_done & (state_q == S_WIDX));
	// a read byte is loaded after the address ack or a master ack
	wire load_w    = scl_fall & ack_q & (
		((state_q == S_ADDR) & is_read) |
		((state_q == S_RDATA) & mack_q));
	// transaction sequencing, pin drive and index
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q    <= S_IDLE;  // idle bus after reset
			cnt_q      <= '0;
			ack_q      <= 1'b0;
			shift_q    <= '0;
			sda_oe_n_q <= 1'b1;
			idx_q      <= '0;
			mack_q     <= 1'b0;
		end else if (start_det) begin
			// a new transaction opens with its address byte
			state_q    <= S_ADDR;
			cnt_q      <= '0;
			ack_q      <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (stop_det | expire_w) begin
			// stop, or the watchdog, clears the interface
			state_q    <= S_IDLE;
			ack_q      <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (load_w) begin
			// drive the first bit of the next read byte at once
			state_q    <= S_RDATA;
			ack_q      <= 1'b0;
			cnt_q      <= '0;
			sda_oe_n_q <= rd_data[7];
			shift_q    <= {rd_data[6:0], 1'b0};
			idx_q      <= idx_q + 1'b1;
		end else begin
			case (state_q)
				S_ADDR, S_WIDX, S_WDATA: begin
					if (scl_rise & ~ack_q) begin
						// one bit per pulse, no limit on byte count
						shift_q <= {shift_q[6:0], sda_s};
						cnt_q   <= cnt_q + 1'b1;
					end else if (byte_done) begin
						// pull low across the whole ninth pulse
						ack_q      <= 1'b1;
						sda_oe_n_q <= ~ack_give;
						if ((state_q == S_ADDR) & ~addr_hit) begin
							state_q <= S_IGNORE;
						end
						if (state_q == S_WIDX) begin
							idx_q <= shift_q[3:0];  // upper bits dropped
						end
						if (push_w) begin
							idx_q <= idx_q + 1'b1;
						end
					end else if (scl_fall & ack_q) begin
						// release after the ack pulse, next byte
						ack_q      <= 1'b0;
						cnt_q      <= '0;
						sda_oe_n_q <= 1'b1;
						if (state_q == S_ADDR) begin
							state_q <= S_WIDX;
						end else if (state_q == S_WIDX) begin
							state_q <= S_WDATA;
						end
					end
				end
				S_RDATA: begin
					if (scl_rise & ~ack_q) begin
						cnt_q <= cnt_q + 1'b1;
					end else if (scl_fall & ~ack_q) begin
						if (cnt_q == rtc_i2c_pkg::ACK_SLOT) begin
							sda_oe_n_q <= 1'b1;  // master owns the slot
							ack_q      <= 1'b1;
						end else begin
							sda_oe_n_q <= shift_q[7];
							shift_q    <= {shift_q[6:0], 1'b0};
						end
					end else if (scl_rise & ack_q) begin
						mack_q <= ~sda_s;
					end else if (scl_fall & ack_q) begin
						// no-ack ends the read: keep data released
						ack_q   <= 1'b0;
						state_q <= S_IGNORE;
					end
				end
				default: begin
					// idle or not addressed: data stays released
					sda_oe_n_q <= 1'b1;
				end
			endcase
		end
	end
	// prescaler, watchdog and freeze
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pre_q    <= '0;
			wd_cnt_q <= '0;
			freeze_q <= 1'b0;
		end else begin
			pre_q <= tick_w ? '0 : pre_q + 1'b1;
			if (start_det | stop_det | expire_w) begin
				freeze_q <= 1'b0;
			end else if (claim_w) begin
				freeze_q <= 1'b1;
				wd_cnt_q <= '0;
			end else if (freeze_q & tick_w) begin
				wd_cnt_q <= wd_cnt_q + 1'b1;
			end
		end
	end

	// ****************************************
	// user side outputs
	// ****************************************
	logic       rd_take_q;  // a read byte was just loaded
	logic       tick_q;     // tick passed on to the time counters
	logic       expire_q;   // watchdog expiry pulse
	logic       busy_q;     // transaction in progress
	// ticks during an access are dropped; expiry passes its own tick,
	// so exactly the first one, one second, is lost
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_take_q <= 1'b0;
			tick_q    <= 1'b0;
			expire_q  <= 1'b0;
			busy_q    <= 1'b0;
		end else begin
			rd_take_q <= load_w;
			tick_q    <= tick_w & (~freeze_q | expire_w);
			expire_q  <= expire_w;
			busy_q    <= state_q != S_IDLE;
		end
	end

	// write bytes with their index queue here for the register file
	rtc_sync_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_DEPTH)
	) rtc_sync_fifo_i (
		.mclk      (mclk),
		.reset     (reset),
		.in_valid  (push_w),
		.in_ready  (push_rdy),
		.in_data   ({idx_q, shift_q}),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  ({wr_idx, wr_data})
	);

	// data pin is open drain only; there is no clock output
	assign link.dev_sda_o    = 1'b0;
	assign link.dev_sda_oe_n = sda_oe_n_q;
	assign rd_idx            = idx_q;
	assign rd_take           = rd_take_q;
	assign freeze            = freeze_q;
	assign sec_tick          = tick_q;
	assign wdog_expire       = expire_q;
	assign busy              = busy_q;
endmodule

// File: rtc_i2c_master.sv
// two-wire bus master that writes and reads the rtc slave
`timescale 1ns/1ns
module rtc_i2c_master #(
	parameter int STEP_CYCLES = rtc_i2c_pkg::STEP_CYCLES
) (
	input  wire logic       mclk,
	input  wire logic       reset,
	i2c_link_if.host        link,
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire logic       cmd_read,
	input  wire logic [6:0] cmd_addr,
	input  wire logic [3:0] cmd_idx,
	input  wire logic [7:0] cmd_len,
	input  wire logic       wd_valid,
	output logic            wd_ready,
	input  wire logic [7:0] wd_data,
	output logic            rd_valid,
	output logic [7:0]      rd_data,
	output logic            done,
	output logic            nack
);
	localparam int SW = $clog2(STEP_CYCLES + 1);

	typedef enum logic [3:0] {
		H_IDLE, H_START, H_LO, H_HI, H_SMP, H_WAIT,
		H_STOP_LO, H_STOP_HI, H_STOP_REL
	} host_state_e;
	typedef enum logic [2:0] {
		P_ADDR, P_IDX, P_WDATA, P_RADDR, P_RDATA
	} host_phase_e;

	// ****************************************
	// step divider and data synchroniser
	// ****************************************
	logic [SW-1:0] step_q;     // cycles toward the next step
	logic [1:0]    sda_sync_q; // data pin, two-stage synchroniser

	wire en_w  = step_q == SW'(STEP_CYCLES - 1);
	wire sda_s = sda_sync_q[1];

	// free running step enable; one clock period spans three steps
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			step_q     <= '0;
			sda_sync_q <= 2'h3;
		end else begin
			step_q     <= en_w ? '0 : step_q + 1'b1;
			sda_sync_q <= {sda_sync_q[0], link.sda};
		end
	end

	// ****************************************
	// transfer sequencer
	// ****************************************
	host_state_e st_q;       // bit level state
	host_phase_e ph_q;       // which byte of the transaction
	logic [7:0]  sh_q;       // transmit and receive shifter
	logic [3:0]  cnt_q;      // bits done in this byte
	logic [7:0]  len_q;      // data bytes still to move
	logic [6:0]  addr_q;     // slave address of this command
	logic [3:0]  idx_q;      // word index, held from accept on
	logic        restart_q;  // read pending after index write
	logic        scl_low_q;  // pull clock low
	logic        sda_low_q;  // pull data low
	logic        ready_q, wd_ready_q, rd_valid_q, done_q, nack_q;
	logic [7:0]  rd_data_q;  // last byte read

	wire rx_w   = ph_q == P_RDATA;
	wire last_w = len_q == 8'h01;
	wire slot_w = cnt_q == rtc_i2c_pkg::ACK_SLOT;

	// the bus is taken only from idle, one command at a time
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st_q <= H_IDLE;
			ph_q <= P_ADDR;
			sh_q <= '0;
			cnt_q <= '0;
			len_q <= '0;
			addr_q <= '0;
			idx_q <= '0;
			restart_q <= 1'b0;
			scl_low_q <= 1'b0;  // both lines released: idle
			sda_low_q <= 1'b0;
			ready_q <= 1'b0;
			wd_ready_q <= 1'b0;
			rd_valid_q <= 1'b0;
			done_q <= 1'b0;
			nack_q <= 1'b0;
			rd_data_q <= '0;
		end else begin
			rd_valid_q <= 1'b0;
			done_q     <= 1'b0;
			if (st_q == H_IDLE) begin
				ready_q <= 1'b1;
				if (cmd_valid & ready_q) begin
					ready_q   <= 1'b0;
					nack_q    <= 1'b0;
					addr_q    <= cmd_addr;
					idx_q     <= cmd_idx;
					len_q     <= cmd_len;
					restart_q <= cmd_read;
					sh_q      <= {cmd_addr, ~rtc_i2c_pkg::RW_READ};
					ph_q      <= P_ADDR;
					st_q      <= H_START;
				end
			end else if (st_q == H_WAIT) begin
				// stall the link until the next write byte arrives
				wd_ready_q <= 1'b1;
				if (wd_valid & wd_ready_q) begin
					wd_ready_q <= 1'b0;
					sh_q       <= wd_data;
					st_q       <= H_LO;
				end
			end else if (en_w) begin
				case (st_q)
					H_START: begin
						sda_low_q <= 1'b1;  // data falls, clock high
						cnt_q     <= '0;
						st_q      <= H_LO;
					end
					H_LO: begin
						// data changes only while the clock is low
						scl_low_q <= 1'b1;
						if (!slot_w) begin
							sda_low_q <= ~rx_w & ~sh_q[7];
						end else begin
							sda_low_q <= rx_w & ~last_w;
						end
						st_q <= H_HI;
					end
					H_HI: begin
						scl_low_q <= 1'b0;
						st_q      <= H_SMP;
					end
					H_SMP: begin
						if (!slot_w) begin
							sh_q  <= {sh_q[6:0], sda_s};
							cnt_q <= cnt_q + 1'b1;
							st_q  <= H_LO;
						end else begin
							// ninth pulse closes the byte
							cnt_q <= '0;
							st_q  <= H_LO;
							case (ph_q)
								P_ADDR, P_WDATA, P_RADDR: begin
									if (sda_s) begin
										nack_q    <= 1'b1;
										restart_q <= 1'b0;
										st_q      <= H_STOP_LO;
									end else if (ph_q == P_ADDR) begin
										sh_q <= {4'h0, idx_q};
										ph_q <= P_IDX;
									end else if (ph_q == P_RADDR) begin
										ph_q <= P_RDATA;
									end else begin
										len_q <= len_q - 1'b1;
										st_q  <= last_w ? H_STOP_LO : H_WAIT;
									end
								end
								P_IDX: begin
									if (restart_q | (len_q == 8'h00)) begin
										st_q <= H_STOP_LO;
									end else begin
										ph_q <= P_WDATA;
										st_q <= H_WAIT;
									end
								end
								default: begin
									rd_valid_q <= 1'b1;
									rd_data_q  <= sh_q;
									len_q      <= len_q - 1'b1;
									// no-ack was given on the last byte
									st_q <= last_w ? H_STOP_LO : H_LO;
								end
							endcase
						end
					end
					H_STOP_LO: begin
						scl_low_q <= 1'b1;
						sda_low_q <= 1'b1;
						st_q      <= H_STOP_HI;
					end
					H_STOP_HI: begin
						scl_low_q <= 1'b0;
						st_q      <= H_STOP_REL;
					end
					default: begin
						sda_low_q <= 1'b0;  // data rises, clock high
						if (restart_q) begin
							restart_q <= 1'b0;
							sh_q      <= {addr_q, rtc_i2c_pkg::RW_READ};
							ph_q      <= P_RADDR;
							st_q      <= H_START;
						end else begin
							done_q <= 1'b1;
							st_q   <= H_IDLE;
						end
					end
				endcase
			end
		end
	end

	// both lines are driven open drain
	assign link.host_scl_o    = 1'b0;
	assign link.host_scl_oe_n = ~scl_low_q;
	assign link.host_sda_o    = 1'b0;
	assign link.host_sda_oe_n = ~sda_low_q;
	assign cmd_ready          = ready_q;
	assign wd_ready           = wd_ready_q;
	assign rd_valid           = rd_valid_q;
	assign rd_data            = rd_data_q;
	assign done               = done_q;
	assign nack               = nack_q;
endmodule

// File: rtc_i2c_chk.sv
// link timing checks between the rtc slave and its bus master
`timescale 1ns/1ns
module rtc_i2c_chk (
	input wire logic mclk,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_oe_n
);
	// ****************************************
	// link framing and timing
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	a_reset_idle: assert property ($fell(reset) |-> scl && sda)
		else $error("bus not idle after reset");
	a_scl_high: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	a_scl_low: assert property ($fell(scl) |-> !scl [*4])
		else $error("clock low phase too short");
	a_start_hold: assert property ($fell(sda) && scl |-> scl [*4])
		else $error("clock fell too soon after start");
	a_stop_idle: assert property ($rose(sda) && scl
		|-> (scl && sda) [*3])
		else $error("bus not idle after stop");
	// only the master may move data while the clock is high
	a_sda_steady: assert property (scl && $past(scl) && $changed(sda)
		|-> $changed(host_sda_oe_n))
		else $error("data moved under a high clock");
	a_dev_low: assert property ($changed(dev_sda_oe_n)
		|-> !scl && !$past(scl))
		else $error("slave moved data outside the low phase");
	a_ack_stands: assert property ($fell(dev_sda_oe_n)
		|-> !dev_sda_oe_n [*8])
		else $error("slave released data too early");
endmodule

// File: rtc_i2c_slave_with_watchdog_tb_top.sv
// bench: slave and master joined, plus a second link left stalled
`timescale 1ns/1ns
module rtc_i2c_slave_with_watchdog_tb_top;
	localparam int         TICKS = 2000;  // shortened one second
	localparam logic [6:0] SA    = rtc_i2c_pkg::SLAVE_ADDR;
	logic       mclk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, cmd_read = 1'b0;
	logic [6:0] cmd_addr = 7'h00;
	logic [3:0] cmd_idx = 4'h0, wr_idx, rd_idx;
	logic [7:0] cmd_len = 8'h00, wd_data = 8'h00, m_data, wr_data, regs [16];
	logic       wd_valid = 1'b0, wr_ready = 1'b1, cmd_ready, wd_ready, done;
	logic       rd_valid, nack, wr_valid, freeze, sec_tick, wdog_expire, busy;
	logic       frz2, tick2, exp2, busy2, rd_take;
	logic [7:0] wq [$], rq [$];
	int         fails = 0, tests_run = 0, cyc = 0, wcnt = 0, ft = 0, k, t2;
	int         rtk = 0;  // read loads seen while the slave is busy
	wire  [7:0] s_rd = regs[rd_idx];  // register file seen by reads
	i2c_link_if link ();
	i2c_link_if link2 ();  // second link driven by the bench itself
	rtc_i2c_slave #(.TICK_CYCLES(TICKS)) rtc_i2c_slave_i (.mclk(mclk),
		.reset(reset), .link(link.device), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_data(wr_data), .wr_idx(wr_idx),
		.rd_idx(rd_idx), .rd_data(s_rd), .rd_take(rd_take), .freeze(freeze),
		.sec_tick(sec_tick), .wdog_expire(wdog_expire), .busy(busy));
	rtc_i2c_slave #(.TICK_CYCLES(TICKS)) rtc_i2c_slave_b_i (.mclk(mclk),
		.reset(reset), .link(link2.device), .wr_valid(), .wr_ready(1'b1),
		.wr_data(), .wr_idx(), .rd_idx(), .rd_data(8'h00), .rd_take(),
		.freeze(frz2), .sec_tick(tick2), .wdog_expire(exp2), .busy(busy2));
	rtc_i2c_master rtc_i2c_master_i (.mclk(mclk), .reset(reset),
		.link(link.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_idx(cmd_idx),
		.cmd_len(cmd_len), .wd_valid(wd_valid), .wd_ready(wd_ready),
		.wd_data(wd_data), .rd_valid(rd_valid), .rd_data(m_data),
		.done(done), .nack(nack));
	rtc_i2c_chk rtc_i2c_chk_i (.mclk(mclk), .reset(reset), .scl(link.scl),
		.sda(link.sda), .host_sda_oe_n(link.host_sda_oe_n),
		.dev_sda_oe_n(link.dev_sda_oe_n));
	// ****************************************
	// clock, user-side models and timeout
	// ****************************************
	always #2 mclk = ~mclk;
	always @(negedge mclk) begin
		wd_valid <= wq.size() > 0;
		wd_data <= wq.size() > 0 ? wq[0] : 8'h00;
	end
	// pops, captures and a tick-under-freeze count; the timeout ends the run
	always @(posedge mclk) begin
		cyc++;
		if (wd_valid && wd_ready) void'(wq.pop_front());
		if (rd_valid) rq.push_back(m_data);
		if (rd_take && busy) rtk++;
		if (wr_valid && wr_ready) begin
			regs[wr_idx] <= wr_data;
			wcnt++;
		end
		if (freeze && sec_tick && !wdog_expire) ft++;
		if (cyc == 60000) begin
			fails++;
			results();
		end
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task results();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// one master command, waited on until its done pulse
	task run(input logic rd, input logic [6:0] a, input logic [3:0] ix,
		input logic [7:0] n);
		@(negedge mclk);
		{cmd_valid, cmd_read, cmd_addr, cmd_idx, cmd_len} = {1'b1, rd, a, ix, n};
		@(posedge mclk);
		while (cmd_ready !== 1'b1) @(posedge mclk);
		@(negedge mclk);
		cmd_valid = 1'b0;
		while (done !== 1'b1) @(posedge mclk);
		repeat (4) @(negedge mclk);
	endtask
	// one 52 ns pulse on the bench-driven link
	task bit2(input logic v);
		@(negedge mclk);
		link2.host_scl_oe_n = 1'b0;
		repeat (2) @(negedge mclk);
		link2.host_sda_oe_n = v;
		repeat (4) @(negedge mclk);
		link2.host_scl_oe_n = 1'b1;
		repeat (6) @(negedge mclk);
	endtask
	task addr2();
		link2.host_sda_oe_n = 1'b0;
		repeat (6) @(negedge mclk);
		for (int i = 7; i >= 0; i--) bit2(i > 0 ? SA[i-1] : 1'b0);
		bit2(1'b1);
		check({7'h0, frz2}, 8'h01);
	endtask
	initial begin
		{link2.host_scl_o, link2.host_sda_o} = 2'b00;
		{link2.host_scl_oe_n, link2.host_sda_oe_n} = 2'b11;
		for (int i = 0; i < 16; i++) regs[i] = 8'h00;
		repeat (20) @(negedge mclk);
		reset = 1'b0;
		wq = {8'ha1, 8'hb2, 8'hc3};
		run(1'b0, SA, 4'hf, 8'h03);
		check(nack, 8'h00);
		check(regs[4'hf], 8'ha1);
		check(regs[4'h0], 8'hb2);
		check(regs[4'h1], 8'hc3);
		run(1'b1, SA, 4'hf, 8'h03);
		check(rq.size(), 8'h03);
		check(rq[0], 8'ha1);
		check(rq[2], 8'hc3);
		check({4'h0, rd_idx}, 8'h02);
		check({7'h0, freeze}, 8'h00);
		check({7'h0, busy}, 8'h00);
		check(rtk, 8'h03);
		wq = {8'h55};
		run(1'b0, SA ^ 7'h01, 4'h0, 8'h01);
		wq.delete();
		check(nack, 8'h01);
		check(regs[4'h0], 8'hb2);
		wr_ready = 1'b0;
		k = wcnt;
		for (int i = 0; i < 12; i++) wq.push_back(8'h10 + i);
		run(1'b0, SA, 4'h4, 8'h0c);
		wq.delete();
		check(nack, 8'h01);
		@(negedge mclk);
		wr_ready = 1'b1;
		repeat (20) @(negedge mclk);
		check(wcnt - k, 8'h09);
		check(regs[4'hc], 8'h18);
		check(ft, 8'h00);
		addr2();
		k = 0;
		t2 = 0;
		while (exp2 !== 1'b1 && k < 3 * TICKS) begin
			@(posedge mclk);
			k++;
			if (tick2 === 1'b1 && exp2 !== 1'b1) t2++;
		end
		check({7'h0, k >= TICKS - 120 && k <= 2 * TICKS}, 8'h01);
		check({7'h0, tick2}, 8'h01);
		check(t2, 8'h00);
		repeat (4) @(negedge mclk);
		check({frz2, busy2, link2.dev_sda_oe_n}, 8'h01);
		addr2();
		bit2(1'b0);
		link2.host_sda_oe_n = 1'b1;
		t2 = 0;
		repeat (2 * TICKS + 200) @(posedge mclk) if (exp2 === 1'b1) t2++;
		check(t2, 8'h00);
		results();
	end
endmodule
